//--- pkg/atfr_pkg.sv
/*
 * Constants and state type of the task file register block.
 * Assumes a single 10 MHz clock shared with the host port logic.
 */
package atfr_pkg;
    // =========================================================
    // Register addresses (host address lines A2..A0)
    localparam logic [2:0] ADDR_COUNT    = 3'h2;
    localparam logic [2:0] ADDR_SECTOR   = 3'h3;
    localparam logic [2:0] ADDR_CYL_LO   = 3'h4;
    localparam logic [2:0] ADDR_CYL_HI   = 3'h5;
    localparam logic [2:0] ADDR_DEVHEAD  = 3'h6;
    localparam logic [2:0] ADDR_STAT_CMD = 3'h7;
    localparam logic [2:0] ADDR_ALT_CTL  = 3'h6;
    // =========================================================
    // Field positions
    localparam int DH_LBA     = 6;
    localparam int DH_UNIT    = 4;
    localparam int CTL_SRST   = 2;
    localparam int CTL_NOINTR = 1;
    // =========================================================
    // Reset values
    localparam logic [7:0] RST_COUNT   = 8'h01;
    localparam logic [7:0] RST_SECTOR  = 8'h01;
    localparam logic [7:0] RST_CYL     = 8'h00;
    localparam logic [7:0] RST_DEVHEAD = 8'hA0;
    localparam logic [7:0] DH_FIXED    = 8'hA0;
    localparam logic [7:0] DH_FREE     = 8'h5F;
    localparam logic [8:0] FULL_COUNT  = 9'h100;
    // =========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int INIT_TIME_NS  = 1000;
    localparam int INIT_CYC      =
        (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] INIT_CNT = 4'(INIT_CYC);
    // =========================================================
    // Block state
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] sector;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] devhead;
        logic       busy;
        logic       ready;
        logic       write_fault_flag;
        logic       seek_done_flag;
        logic       transfer_window_open;
        logic       corrected_flag;
        logic       err;
        logic       interrupt_disable_bit;
        logic       srst;
        logic       irq;
        logic       init;
        logic [3:0] init_cnt;
        logic [7:0] cmd;
        logic       start;
        logic [7:0] rdata;
        logic       sync1;
        logic       sync2;
    } atfr_state_t;
endpackage

//--- rtl/atfr_task_file.sv
/*
 * Task file register block: address registers, drive/head,
 * status with its alternate copy, command and device control.
 * Assumes host strobes and back-end events are one-cycle
 * pulses on clk; only the unit number pin is asynchronous.
 */
`timescale 1ns/1ps
module atfr_task_file
    import atfr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [2:0]  host_addr,
    input  wire logic        host_alt_sel,
    input  wire logic        host_rd,
    input  wire logic        host_wr,
    input  wire logic [7:0]  host_wdata,
    output logic      [7:0]  host_rdata,
    input  wire logic [1:0]  cfg_index,
    input  wire logic        cfg_level_irq,
    input  wire logic        cfg_copy_unit,
    input  wire logic        unit_number_pin,
    input  wire logic        be_done,
    input  wire logic        be_error,
    input  wire logic        be_fault,
    input  wire logic        be_corrected,
    input  wire logic        be_seek_done,
    input  wire logic        be_window_open,
    input  wire logic        be_window_close,
    output logic             cmd_start,
    output logic      [7:0]  cmd_code,
    output logic             lba_mode,
    output logic      [27:0] lba_addr,
    output logic      [8:0]  xfer_sectors,
    output logic             unit_select_bit,
    output logic             task_reset,
    output logic      [7:0]  status_view,
    output logic             intr_req
);
    import atfr_pkg::*;

    atfr_state_t q;
    atfr_state_t d;
    logic        own_unit;
    logic        selected;
    logic        io_level;
    logic        tf_wr;
    logic        cmd_wr;
    logic        media_cmd;
    logic        refused;
    logic        stat_rd;
    logic        alt_rd;
    logic        done_ev;
    logic [7:0]  status;

    // =========================================================
    // Status and decode
    always_comb
    begin
        status = {q.busy, q.ready, q.write_fault_flag, q.seek_done_flag,
                  q.transfer_window_open, q.corrected_flag, 1'b0, q.err};
        own_unit = q.sync2 | cfg_copy_unit;
        selected = (q.devhead[DH_UNIT] == own_unit);
        io_level = (cfg_index != 2'h0) && cfg_level_irq;
        tf_wr = host_wr && !host_alt_sel && !q.busy;
        cmd_wr = tf_wr && selected
              && (host_addr == ADDR_STAT_CMD);
        media_cmd = (host_wdata[7:4] == 4'h2)
                 || (host_wdata[7:4] == 4'h3)
                 || (host_wdata[7:4] == 4'h4)
                 || (host_wdata[7:4] == 4'h7)
                 || (host_wdata == 8'hC4)
                 || (host_wdata == 8'hC5)
                 || (host_wdata == 8'hCD);
        refused = media_cmd && !(q.ready && q.seek_done_flag);
        stat_rd = host_rd && !host_alt_sel && selected
               && (host_addr == ADDR_STAT_CMD);
        alt_rd = host_rd && host_alt_sel
              && (host_addr == ADDR_ALT_CTL);
        done_ev = be_done && q.busy && !q.init;
    end

    // =========================================================
    // Next state
    always_comb
    begin
        d = q;
        d.start = 1'b0;
        d.sync1 = unit_number_pin;
        d.sync2 = q.sync1;
        // Reads: the mirror is the same bits, only the primary read acks.
        if (host_rd)
        begin
            d.rdata = 8'h00;
            if (alt_rd && selected)
            begin
                d.rdata = status;
            end
            else if (!host_alt_sel && selected)
            begin
                case (host_addr)
                    ADDR_COUNT:    d.rdata = q.count;
                    ADDR_SECTOR:   d.rdata = q.sector;
                    ADDR_CYL_LO:   d.rdata = q.cyl_lo;
                    ADDR_CYL_HI:   d.rdata = q.cyl_hi;
                    ADDR_DEVHEAD:  d.rdata = q.devhead;
                    ADDR_STAT_CMD: d.rdata = status;
                    default:       d.rdata = 8'h00;
                endcase
            end
        end
        if (stat_rd && io_level)
        begin
            d.irq = 1'b0;
        end
        // Task file writes are dropped while busy, as the host may
        // not alter parameters under a running command.
        if (tf_wr)
        begin
            case (host_addr)
                ADDR_COUNT:   d.count = host_wdata;
                ADDR_SECTOR:  d.sector = host_wdata;
                ADDR_CYL_LO:  d.cyl_lo = host_wdata;
                ADDR_CYL_HI:  d.cyl_hi = host_wdata;
                ADDR_DEVHEAD: d.devhead = (host_wdata & DH_FREE)
                                        | DH_FIXED;
                default:      d.devhead = d.devhead;
            endcase
        end
        if (host_wr && host_alt_sel && (host_addr == ADDR_ALT_CTL))
        begin
            d.interrupt_disable_bit = host_wdata[CTL_NOINTR];
            d.srst = host_wdata[CTL_SRST];
        end
        if (cmd_wr)
        begin
            d.transfer_window_open = 1'b0;
            d.corrected_flag = 1'b0;
            d.err = refused;
            if (refused)
            begin
                d.irq = 1'b1;
            end
            else
            begin
                d.busy = 1'b1;
                d.start = 1'b1;
                d.cmd = host_wdata;
                // A seek leaves seek complete low until the back end reports it.
                if (host_wdata[7:4] == 4'h7)
                begin
                    d.seek_done_flag = 1'b0;
                end
            end
        end
        // Back-end events are applied after host clears, so a set wins.
        if (done_ev)
        begin
            d.busy = 1'b0;
            d.err = be_error;
            d.write_fault_flag = be_fault;
            d.corrected_flag = be_corrected;
            d.irq = 1'b1;
        end
        if (be_seek_done)
        begin
            d.seek_done_flag = 1'b1;
        end
        if (be_window_close)
        begin
            d.transfer_window_open = 1'b0;
        end
        if (be_window_open)
        begin
            d.transfer_window_open = 1'b1;
        end
        // Soft reset holds the task file at defaults until released.
        if (q.srst)
        begin
            d.count = RST_COUNT;
            d.sector = RST_SECTOR;
            d.cyl_lo = RST_CYL;
            d.cyl_hi = RST_CYL;
            d.devhead = RST_DEVHEAD;
            d.busy = 1'b1;
            d.ready = 1'b0;
            d.write_fault_flag = 1'b0;
            d.seek_done_flag = 1'b0;
            d.transfer_window_open = 1'b0;
            d.corrected_flag = 1'b0;
            d.err = 1'b0;
            d.irq = 1'b0;
            d.start = 1'b0;
            d.init = 1'b1;
            d.init_cnt = INIT_CNT;
        end
        else if (q.init)
        begin
            d.init_cnt = q.init_cnt - 4'h1;
            if (q.init_cnt == 4'h1)
            begin
                d.init = 1'b0;
                d.busy = 1'b0;
                d.ready = 1'b1;
                d.seek_done_flag = 1'b1;
            end
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            q <= '{count: RST_COUNT, sector: RST_SECTOR,
                   cyl_lo: RST_CYL, cyl_hi: RST_CYL,
                   devhead: RST_DEVHEAD, busy: 1'b1,
                   init: 1'b1, init_cnt: INIT_CNT,
                   default: '0};
        end
        else
        begin
            q <= d;
        end
    end

    // =========================================================
    // Outputs
    assign host_rdata = q.rdata;
    assign cmd_start = q.start;
    assign cmd_code = q.cmd;
    assign lba_mode = q.devhead[DH_LBA];
    assign lba_addr = {q.devhead[3:0], q.cyl_hi,
                       q.cyl_lo, q.sector};
    assign xfer_sectors = (q.count == 8'h00) ? FULL_COUNT
                        : {1'b0, q.count};
    assign unit_select_bit = q.devhead[DH_UNIT];
    assign task_reset = q.srst;
    assign status_view = status;
    assign intr_req = q.irq && !q.interrupt_disable_bit;

    // =========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_sector_load: assert property (
        tf_wr && host_addr == ADDR_SECTOR && !q.srst
        |=> lba_addr[7:0] == $past(host_wdata))
        else $error("sector write not held");
    a_cyl_low: assert property (
        tf_wr && host_addr == ADDR_CYL_LO && !q.srst
        |=> lba_addr[15:8] == $past(host_wdata))
        else $error("cylinder low not held");
    a_cyl_high: assert property (
        tf_wr && host_addr == ADDR_CYL_HI && !q.srst
        |=> lba_addr[23:16] == $past(host_wdata))
        else $error("cylinder high not held");
    a_mode_head: assert property (
        tf_wr && host_addr == ADDR_DEVHEAD && !q.srst
        |=> lba_mode == $past(host_wdata[6])
            && lba_addr[27:24] == $past(host_wdata[3:0]))
        else $error("drive/head fields wrong");
    a_irq_ack: assert property (
        stat_rd && io_level && !done_ev && !cmd_wr
        |=> !intr_req)
        else $error("status read left interrupt");
    a_cmd_start: assert property (
        cmd_wr && !refused && !q.srst
        |=> cmd_start && status_view[7] ##1 !cmd_start)
        else $error("accepted command did not start");
    a_cmd_refuse: assert property (
        cmd_wr && refused && !q.srst
        |=> !cmd_start && status_view[0] && !status_view[7])
        else $error("refused command not flagged");
    a_idx_zero: assert property (
        host_rd && host_addr == ADDR_STAT_CMD
        |=> host_rdata[1] == 1'b0)
        else $error("index bit not zero");
    a_alt_keep: assert property (
        alt_rd && !stat_rd && !done_ev && !cmd_wr && !q.srst
        |=> q.irq == $past(q.irq))
        else $error("alternate read changed interrupt");
    a_irq_mask: assert property (
        q.interrupt_disable_bit |-> !intr_req)
        else $error("interrupt not masked");
    a_done_err: assert property (
        done_ev && !q.srst
        |=> status_view[0] == $past(be_error) && !status_view[7])
        else $error("completion error bit wrong");
    a_init_busy: assert property (
        $fell(q.srst) |-> status_view[7] [*8]
        ##[1:4] status_view[6])
        else $error("init busy period wrong");

    c_cmd_ok: cover property (cmd_wr && !refused ##[1:50] done_ev);
    c_cmd_bad: cover property (cmd_wr && refused);
    c_irq_ack: cover property (intr_req ##[1:20] stat_rd && io_level);
    c_soft_rst: cover property ($fell(q.srst) ##[1:20] !q.busy);
endmodule

//--- tb/atfr_backend_model.sv
/*
 * Behavioural back end that answers accepted commands of the task file.
 * Assumes one command in flight and levels set by the bench beforehand.
 */
`timescale 1ns/1ps
module atfr_backend_model #(
    parameter int DELAY = 5
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic cmd_start,
    input  wire logic err_in,
    input  wire logic fault_in,
    input  wire logic corrected_flag_in,
    input  wire logic window_in,
    input  wire logic seek_miss_in,
    output logic      be_done,
    output logic      be_error,
    output logic      be_fault,
    output logic      be_corrected,
    output logic      be_seek_done,
    output logic      be_window_open
);
    // =========================================================
    // Completion
    initial
    begin
        be_done = 1'b0;
        be_error = 1'b1;
        be_fault = 1'b1;
        be_corrected = 1'b1;
        be_seek_done = 1'b0;
        be_window_open = 1'b0;
    end
    always
    begin
        @(posedge clk);
        if (cmd_start === 1'b1 && reset === 1'b0)
        begin
            repeat (DELAY) @(posedge clk);
            be_done <= 1'b1;
            be_error <= err_in;
            be_fault <= fault_in;
            be_corrected <= corrected_flag_in;
            be_seek_done <= !seek_miss_in;
            be_window_open <= window_in;
            @(posedge clk);
            // Error, fault and corrected levels invert off their sample edge so a stale value cannot pass.
            be_done <= 1'b0;
            be_error <= ~err_in;
            be_fault <= ~fault_in;
            be_corrected <= ~corrected_flag_in;
            be_seek_done <= 1'b0;
            be_window_open <= 1'b0;
        end
    end
endmodule

//--- tb/ata_task_file_registers_test.sv
/*
 * Self-checking bench of the task file block through its byte register port.
 * Assumes host strobes synchronous to clk and the back end model beside it.
 */
`timescale 1ns/1ps
module ata_task_file_registers_test;
    import atfr_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [2:0]  host_addr = 3'h0;
    logic        host_alt_sel = 1'b0;
    logic        host_rd = 1'b0;
    logic        host_wr = 1'b0;
    logic [7:0]  host_wdata = 8'h00;
    logic [7:0]  host_rdata, cmd_code, status_view;
    logic        cmd_start, lba_mode, unit_select_bit, task_reset, intr_req;
    logic [27:0] lba_addr;
    logic [8:0]  xfer_sectors;
    logic        be_done, be_error, be_fault, be_corrected, be_seek_done, be_window_open;
    logic        err_in = 1'b0, fault_in = 1'b0, corrected_flag_in = 1'b0, window_in = 1'b0;
    logic        seek_miss_in = 1'b0, level_irq = 1'b1, unit_pin = 1'b0;
    int          n_errors = 0;
    int          checks = 0;

    always #50 clk = ~clk;

    atfr_task_file dut (.clk(clk), .reset(reset), .host_addr(host_addr), .host_alt_sel(host_alt_sel),
        .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .cfg_index(2'h1), .cfg_level_irq(level_irq), .cfg_copy_unit(1'b0), .unit_number_pin(unit_pin),
        .be_done(be_done), .be_error(be_error), .be_fault(be_fault), .be_corrected(be_corrected),
        .be_seek_done(be_seek_done), .be_window_open(be_window_open), .be_window_close(1'b0),
        .cmd_start(cmd_start), .cmd_code(cmd_code), .lba_mode(lba_mode), .lba_addr(lba_addr),
        .xfer_sectors(xfer_sectors), .unit_select_bit(unit_select_bit), .task_reset(task_reset),
        .status_view(status_view), .intr_req(intr_req));

    atfr_backend_model #(.DELAY(5)) partner (.clk(clk), .reset(reset), .cmd_start(cmd_start),
        .err_in(err_in), .fault_in(fault_in), .corrected_flag_in(corrected_flag_in), .window_in(window_in),
        .seek_miss_in(seek_miss_in),
        .be_done(be_done), .be_error(be_error), .be_fault(be_fault), .be_corrected(be_corrected),
        .be_seek_done(be_seek_done), .be_window_open(be_window_open));

    // =========================================================
    // Access tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
            n_errors++;
        end
    endtask

    task automatic tally_and_finish;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic alt, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        host_alt_sel <= alt;
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge clk);
        host_wr <= 1'b0;
        #1;
    endtask

    // Byte reads only; word pairing is never used on status.
    task automatic rd_chk(input logic alt, input logic [2:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        host_alt_sel <= alt;
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge clk);
        host_rd <= 1'b0;
        #1;
        check(name, host_rdata, exp);
    endtask

    task automatic wait_idle;
        for (int i = 0; i < 100; i++)
        begin
            @(posedge clk);
            #1;
            if (status_view[7] === 1'b0)
                return;
        end
        n_errors++;
        tally_and_finish;
    endtask

    task automatic run_cmd(input logic [7:0] code, input logic [4:0] efcw, input logic [7:0] exp);
        {seek_miss_in, err_in, fault_in, corrected_flag_in, window_in} <= efcw;
        wr(1'b0, ADDR_STAT_CMD, code);
        check("cmd_start", cmd_start, 1);
        check("cmd_code", cmd_code, code);
        check("busy", status_view[7], 1);
        wait_idle;
        check("irq done", intr_req, 1);
        rd_chk(1'b1, ADDR_ALT_CTL, exp, "alt status");
        check("irq alt", intr_req, 1);
        rd_chk(1'b0, ADDR_STAT_CMD, exp, "status");
        check("irq ack", intr_req, 0);
    endtask

    // =========================================================
    // Sequence
    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        check("rst status", status_view, 8'h80);
        check("rst irq", intr_req, 0);
        @(posedge clk);
        reset <= 1'b0;
        wait_idle;
        check("init status", status_view, 8'h50);
        wr(1'b0, ADDR_SECTOR, 8'h12);
        wr(1'b0, ADDR_CYL_LO, 8'h34);
        wr(1'b0, ADDR_CYL_HI, 8'h56);
        wr(1'b0, ADDR_DEVHEAD, 8'h47);
        wr(1'b0, ADDR_COUNT, 8'h00);
        rd_chk(1'b0, ADDR_SECTOR, 8'h12, "sector");
        rd_chk(1'b0, ADDR_CYL_LO, 8'h34, "cyl lo");
        rd_chk(1'b0, ADDR_CYL_HI, 8'h56, "cyl hi");
        rd_chk(1'b0, ADDR_DEVHEAD, 8'hE7, "devhead");
        check("lba mode", lba_mode, 1);
        check("lba addr", lba_addr, 28'h7563412);
        check("unit", unit_select_bit, 0);
        check("count 0", xfer_sectors, 9'h100);
        wr(1'b0, ADDR_DEVHEAD, 8'h03);
        check("chs mode", lba_mode, 0);
        check("head", lba_addr[27:24], 4'h3);
        run_cmd(8'h20, 5'h08, 8'h51);
        run_cmd(8'hEC, 5'h01, 8'h58);
        run_cmd(8'h30, 5'h06, 8'h74);
        wr(1'b1, ADDR_ALT_CTL, 8'h08);
        run_cmd(8'h20, 5'h00, 8'h50);
        run_cmd(8'h70, 5'h10, 8'h40);
        wr(1'b0, ADDR_STAT_CMD, 8'h20);
        check("refused start", cmd_start, 0);
        check("refused status", status_view, 8'h41);
        check("refused irq", intr_req, 1);
        rd_chk(1'b0, ADDR_STAT_CMD, 8'h41, "refused read");
        run_cmd(8'h10, 5'h00, 8'h50);
        wr(1'b1, ADDR_ALT_CTL, 8'h0A);
        {err_in, fault_in, corrected_flag_in, window_in} <= 4'h0;
        wr(1'b0, ADDR_STAT_CMD, 8'hE5);
        wait_idle;
        check("irq masked", intr_req, 0);
        wr(1'b1, ADDR_ALT_CTL, 8'h08);
        check("irq unmasked", intr_req, 1);
        rd_chk(1'b0, ADDR_STAT_CMD, 8'h50, "status");
        check("irq read ack", intr_req, 0);
        level_irq <= 1'b0;
        wr(1'b0, ADDR_STAT_CMD, 8'hE5);
        wait_idle;
        rd_chk(1'b0, ADDR_STAT_CMD, 8'h50, "edge mode status");
        check("irq kept", intr_req, 1);
        level_irq <= 1'b1;
        rd_chk(1'b0, ADDR_STAT_CMD, 8'h50, "level mode status");
        check("irq cleared", intr_req, 0);
        wr(1'b0, ADDR_DEVHEAD, 8'h10);
        check("unit 1", unit_select_bit, 1);
        wr(1'b0, ADDR_STAT_CMD, 8'h20);
        check("other unit", cmd_start, 0);
        rd_chk(1'b0, ADDR_STAT_CMD, 8'h00, "unselected");
        unit_pin <= 1'b1;
        repeat (2) @(posedge clk);
        rd_chk(1'b0, ADDR_STAT_CMD, 8'h50, "pin unit 1");
        unit_pin <= 1'b0;
        wr(1'b1, ADDR_ALT_CTL, 8'h0C);
        check("srst level", task_reset, 1);
        @(posedge clk);
        #1;
        check("srst busy", status_view[7], 1);
        wr(1'b1, ADDR_ALT_CTL, 8'h08);
        wait_idle;
        check("srst status", status_view, 8'h50);
        rd_chk(1'b0, ADDR_DEVHEAD, RST_DEVHEAD, "srst devhead");
        rd_chk(1'b0, ADDR_SECTOR, RST_SECTOR, "srst sector");
        check("srst lba", lba_addr, 28'h0000001);
        check("srst count", xfer_sectors, 9'h001);
        tally_and_finish;
    end
endmodule
